/* tb/hms_checker_asserts.sv */
// hms_checker: port-level assertions for the measurement scheduler.
// assumes one clock, active-low reset, and a bench that holds thermal
// inputs steady around thermal checks.
module hms_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [5:0] avAddress,
  input wire logic avWrite,
  input wire logic avWaitRequest,
  input wire logic sleepFlag,
  input wire logic sourceMeasureInhibit,
  input wire logic thermalMonitorEnable,
  input wire logic thermalHot,
  input wire logic interruptAssert,
  input wire logic sourceDischargeOut,
  input wire logic interruptPinOut,
  input wire logic interruptPinOe,
  input wire logic [2:0] wakeThresholdCode,
  input wire logic [4:0] mpptFractionCode,
  input wire logic sourceMeasureActive,
  input wire logic sourceMeasureDone,
  input wire logic thermalCheckStrobe,
  input wire logic boostThermalHalt,
  input wire logic harvestEnable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////
  // multi-step behaviours
  sequence s_meas_end;
    $fell(sourceMeasureActive);
  endsequence
  sequence s_thm_seen;
    thermalCheckStrobe && thermalMonitorEnable ##1 $stable(thermalHot)
      ##1 $stable(thermalHot);
  endsequence
  ////////////////////////////////////////////////////////////////////
  a_harvest_sleep: assert property (
    harvestEnable == !sleepFlag) else $error("harvest enable wrong");
  a_irq_enable: assert property (
    interruptAssert |-> interruptPinOe) else $error("irq pin not driven");
  a_pin_drive: assert property (
    interruptPinOe && interruptPinOut |-> sourceDischargeOut)
    else $error("pin driven high without discharge");
  a_done_pulse: assert property (
    sourceMeasureDone |=> !sourceMeasureDone) else $error("done too long");
  a_done_follows: assert property (
    s_meas_end |-> ##[0:3] sourceMeasureDone) else $error("no done pulse");
  a_inhibit_block: assert property (
    $rose(sourceMeasureActive) |-> !$past(sourceMeasureInhibit))
    else $error("measurement while inhibited");
  a_thm_enable: assert property (
    thermalCheckStrobe |-> $past(thermalMonitorEnable))
    else $error("thermal check while disabled");
  a_thm_pulse: assert property (
    thermalCheckStrobe |=> !thermalCheckStrobe) else $error("strobe long");
  a_halt_hot: assert property (
    s_thm_seen |-> boostThermalHalt == thermalHot)
    else $error("halt does not follow thermal result");
  a_wake_hold: assert property (
    !(avWrite && !avWaitRequest && avAddress == 6'h14)
    |=> $stable(wakeThresholdCode)) else $error("wake code changed");
  a_frac_hold: assert property (
    !(avWrite && !avWaitRequest && avAddress == 6'h18)
    |=> $stable(mpptFractionCode)) else $error("fraction code changed");
endmodule

/* tb/hms_host_model.sv */
// hms_host_model: Avalon-MM host that programs the scheduler registers.
// assumes the slave answers through waitrequest; no timeout of its own.
module hms_host_model (
  input wire logic clk,
  output logic [5:0] avAddress,
  output logic avRead,
  output logic avWrite,
  output logic [31:0] avWriteData,
  output logic [3:0] avByteEnable,
  input wire logic [31:0] avReadData,
  input wire logic avWaitRequest
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    avAddress = 6'h0;
    avRead = 1'h0;
    avWrite = 1'h0;
    avWriteData = 32'h0;
    avByteEnable = 4'hF;
  end
  ////////////////////////////////////////////////////////////////////
  // one write, held until waitrequest is seen low; the result register
  // is never written, so a pending forced request is left alone
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    avAddress <= a;
    avWriteData <= {24'h0, d};
    avWrite <= 1'h1;
    do @(posedge clk); while (avWaitRequest);
    avWrite <= 1'h0;
    avAddress <= ~a; // released lines do not keep the old value
    avWriteData <= ~{24'h0, d};
  endtask
  // one read; data taken at the edge that ends the wait
  task rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    avAddress <= a;
    avRead <= 1'h1;
    do @(posedge clk); while (avWaitRequest);
    d = avReadData;
    avRead <= 1'h0;
    avAddress <= ~a;
  endtask
endmodule

/* tb/test_hms_scheduler.sv */
// test_hms_scheduler: self-checking bench for the measurement scheduler.
// assumes a 1 ms tick shortened to TCK cycles; host model drives the bus.
module test_hms_scheduler;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TCK = 4;
  typedef struct {logic [5:0] a; logic [7:0] w; logic [7:0] r;} hms_row_type;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [15:0] harvestPulseCount = 16'h0;
  logic sleepFlag = 1'h0, sourceMeasureInhibit = 1'h0;
  logic thermalMonitorEnable = 1'h0, thermalHot = 1'h0;
  logic interruptAssert = 1'h0, sourceDischargeOut = 1'h0;
  logic [5:0] avAddress;
  logic avRead, avWrite, avWaitRequest, interruptPinOut, interruptPinOe;
  logic [31:0] avWriteData, avReadData, rd;
  logic [3:0] avByteEnable;
  logic [2:0] wakeThresholdCode;
  logic [4:0] mpptFractionCode;
  logic sourceMeasureActive, sourceMeasureDone, thermalCheckStrobe;
  logic boostThermalHalt, harvestEnable, sa, st;
  int fails = 0, num_checks = 0, nDone = 0, nThm = 0, cyc = 0, d;
  hms_row_type rows [9] = '{'{6'h14, 8'h03, 8'h03}, '{6'h14, 8'hD6, 8'hD6},
    '{6'h18, 8'h00, 8'h00}, '{6'h18, 8'hFF, 8'h1F}, '{6'h1C, 8'h3F, 8'h3F},
    '{6'h1C, 8'hC3, 8'h03}, '{6'h00, 8'hFF, 8'h00}, '{6'h3C, 8'hFF, 8'h00},
    '{6'h18, 8'h0A, 8'h0A}};
  hms_row_type rst [3] = '{'{6'h14, 8'h00, 8'h87}, '{6'h18, 8'h00, 8'h19},
    '{6'h1C, 8'h00, 8'h0E}};
  int stab [8][3] = '{'{8'h03, 0, 50}, '{8'h13, 0, 100}, '{8'h23, 0, 250},
    '{8'h33, 0, 500}, '{8'h0B, 16'h1000, 12}, '{8'h0B, 16'h0100, 25},
    '{8'h0B, 16'h0010, 50}, '{8'h0B, 0, 100}};

  hms_scheduler #(.TICK_CYCLES(TCK)) i_dut (.clk, .resetn, .avAddress,
    .avRead, .avWrite, .avWriteData, .avByteEnable, .avReadData,
    .avWaitRequest, .harvestPulseCount, .sleepFlag, .sourceMeasureInhibit,
    .thermalMonitorEnable, .thermalHot, .interruptAssert,
    .sourceDischargeOut, .interruptPinOut, .interruptPinOe,
    .wakeThresholdCode, .mpptFractionCode, .sourceMeasureActive,
    .sourceMeasureDone, .thermalCheckStrobe, .boostThermalHalt,
    .harvestEnable);
  hms_host_model i_host (.clk, .avAddress, .avRead, .avWrite, .avWriteData,
    .avByteEnable, .avReadData, .avWaitRequest);

  ////////////////////////////////////////////////////////////////////
  // clock, event counters and hang limit
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (sourceMeasureDone === 1'h1) nDone++;
    if (thermalCheckStrobe === 1'h1) nThm++;
    if (cyc == 60000) begin
      fails++;
      test_done();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watch strobes for twenty cycles
  task watch();
    sa = 1'h0;
    st = 1'h0;
    repeat (20) begin
      @(negedge clk);
      sa |= sourceMeasureActive;
      st |= thermalCheckStrobe;
    end
  endtask
  // force one measurement and return its settling length in cycles
  task run_meas(input logic [7:0] cfg, output int n);
    n = 0;
    while (sourceMeasureActive !== 1'h0) @(negedge clk);
    i_host.wr(6'h1C, cfg | 8'h80);
    for (int i = 0; i < 10 && !sourceMeasureActive; i++) @(negedge clk);
    while (sourceMeasureActive === 1'h1) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk); // let the done pulse of this measurement pass
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'h1;
    foreach (rows[k]) begin
      i_host.wr(rows[k].a, rows[k].w);
      i_host.rd(rows[k].a, rd);
      chk("regRead", {24'h0, rows[k].r}, rd);
      if (rows[k].a == 6'h14) chk("wake", rows[k].w[2:0], wakeThresholdCode);
      if (rows[k].a == 6'h18) chk("frac", rows[k].w[4:0], mpptFractionCode);
    end
    // reset in mid-run restores defaults and the power-on measurement
    @(posedge clk) resetn <= 1'h0;
    repeat (5) @(posedge clk);
    resetn <= 1'h1;
    foreach (rst[k]) begin
      i_host.rd(rst[k].a, rd);
      chk("resetVal", {24'h0, rst[k].r}, rd);
    end
    chk("porMeas", 1, sourceMeasureActive);
    i_host.wr(6'h1C, 8'h03);
    // settling time per code and harvest level
    foreach (stab[k]) begin
      @(posedge clk) harvestPulseCount <= 16'(stab[k][1]);
      run_meas(8'(stab[k][0]), d);
      chk("settle", 1, (d > stab[k][2] * TCK - 9) && (d < stab[k][2] * TCK + 9));
    end
    // forced measurement refused while inhibited
    @(posedge clk) sourceMeasureInhibit <= 1'h1;
    i_host.wr(6'h1C, 8'h83);
    watch();
    chk("inhibit", 0, sa);
    @(posedge clk) sourceMeasureInhibit <= 1'h0;
    // forced thermal check, disabled then enabled, hot then cool
    @(posedge clk) thermalHot <= 1'h1;
    i_host.wr(6'h1C, 8'h43);
    watch();
    chk("thmOff", 0, st);
    @(posedge clk) thermalMonitorEnable <= 1'h1;
    repeat (3) @(posedge clk);
    i_host.wr(6'h1C, 8'h43);
    watch();
    chk("thmOn", 1, st);
    chk("haltHot", 1, boostThermalHalt);
    @(posedge clk) thermalHot <= 1'h0;
    i_host.wr(6'h1C, 8'h43);
    watch();
    chk("haltCool", 0, boostThermalHalt);
    // interrupt pin modes and sleep
    for (int m = 0; m < 2; m++) begin
      i_host.wr(6'h14, m ? 8'h17 : 8'h07);
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        interruptAssert <= k[0];
        sourceDischargeOut <= k[1];
        sleepFlag <= k[1];
        @(negedge clk);
        chk("pinOe", m ? 1 : k[0], interruptPinOe);
        if (interruptPinOe) chk("pinOut", m ? k[1] : 0, interruptPinOut);
        chk("harvest", !k[1], harvestEnable);
      end
    end
    @(posedge clk) sleepFlag <= 1'h0;
    // automatic period of 64 x 50 ms, then periodic bits cleared
    for (int m = 0; m < 2; m++) begin
      i_host.wr(6'h14, m ? 8'h07 : 8'hC7);
      run_meas(8'h00, d);
      nDone = 0;
      nThm = 0;
      repeat (13100) @(negedge clk);
      chk("perMeas", m ? 0 : 1, nDone);
      chk("perThm", m ? 0 : 1, nThm);
    end
    // adaptive period: capture after 2 x 50 ms, then a fourfold rise forces
    @(posedge clk) harvestPulseCount <= 16'h0100;
    run_meas(8'h04, d);
    repeat (420) @(negedge clk);
    i_host.rd(6'h30, rd);
    chk("stored", 32'h01000041, rd);
    @(posedge clk) harvestPulseCount <= 16'h0400;
    watch();
    chk("ratio", 1, sa);
    test_done();
  end
endmodule

bind hms_scheduler hms_checker i_chk (.clk, .resetn, .avAddress, .avWrite,
  .avWaitRequest, .sleepFlag, .sourceMeasureInhibit, .thermalMonitorEnable,
  .thermalHot, .interruptAssert, .sourceDischargeOut, .interruptPinOut,
  .interruptPinOe, .wakeThresholdCode, .mpptFractionCode,
  .sourceMeasureActive, .sourceMeasureDone, .thermalCheckStrobe,
  .boostThermalHalt, .harvestEnable);

/* verilog/hms_pkg.sv */
// hms_pkg: register map, field positions, reset values, timing
// constants and carrier types of the harvest measurement scheduler.
// assumes a 50 MHz system clock and a 32-bit Avalon-MM register port.
package hms_pkg;

  ////////////////////////////////////////////////////////////////////////
  // clock and time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_TIME_NS = 1000000; // one millisecond time base
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

  // base settling times in milliseconds, codes 0 to 3
  localparam logic [11:0] TMEAS0_MS = 12'd50;
  localparam logic [11:0] TMEAS1_MS = 12'd100;
  localparam logic [11:0] TMEAS2_MS = 12'd250;
  localparam logic [11:0] TMEAS3_MS = 12'd500;

  // period multiplier exponent base: 64 x Tmeas for code 0
  localparam int PERIOD_SHIFT_BASE = 6;
  localparam logic [1:0] TPER_DISABLED = 2'h3;

  // adaptive settle thresholds on the harvest pulse count
  localparam logic [15:0] HARV_FAST = 16'h1000;
  localparam logic [15:0] HARV_MID = 16'h0100;
  localparam logic [15:0] HARV_SLOW = 16'h0010;

  ////////////////////////////////////////////////////////////////////////
  // register indexes; byte address is four times the index
  localparam logic [3:0] IDX_WAKE_PERIOD = 4'h5;
  localparam logic [3:0] IDX_MPPT_FRAC = 4'h6;
  localparam logic [3:0] IDX_MEAS_CFG = 4'h7;
  localparam logic [3:0] IDX_SCHED_STATUS = 4'hC;

  // wake_and_period_config fields
  localparam int WK_PERIODIC_SRC = 7;
  localparam int WK_PERIODIC_THM = 6;
  localparam int WK_DISCH_SEL = 4;
  localparam int WK_THR_LSB = 0;
  // measurement_config fields
  localparam int MC_FORCE_SRC = 7;
  localparam int MC_FORCE_THM = 6;
  localparam int MC_TMEAS_LSB = 4;
  localparam int MC_ADAPT_SETTLE = 3;
  localparam int MC_ADAPT_PERIOD = 2;
  localparam int MC_TPER_LSB = 0;

  // reset values
  localparam logic RST_PERIODIC_SRC = 1'h1;
  localparam logic RST_PERIODIC_THM = 1'h0;
  localparam logic RST_DISCH_SEL = 1'h0;
  localparam logic [2:0] RST_WAKE_THR = 3'h7;
  localparam logic [4:0] RST_FRAC = 5'h19;
  localparam logic [1:0] RST_TMEAS = 2'h0;
  localparam logic RST_ADAPT_SETTLE = 1'h1;
  localparam logic RST_ADAPT_PERIOD = 1'h1;
  localparam logic [1:0] RST_TPER = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // software configuration carried as one word
  typedef struct packed {
    logic periodicSourceMeasureEn;
    logic periodicThermalEn;
    logic irqPinToDischargeSel;
    logic [2:0] wakeThresholdCode;
    logic [4:0] mpptFraction;
    logic [1:0] tmeasCode;
    logic adaptiveSettleEn;
    logic adaptivePeriodEn;
    logic [1:0] tperCode;
  } hms_cfg_type;

  localparam hms_cfg_type CFG_RESET = '{RST_PERIODIC_SRC, RST_PERIODIC_THM,
    RST_DISCH_SEL, RST_WAKE_THR, RST_FRAC, RST_TMEAS, RST_ADAPT_SETTLE,
    RST_ADAPT_PERIOD, RST_TPER};

  // scheduler states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SETTLE = 3'b010,
    ST_DONE = 3'b100
  } hms_state_type;

  // base settling time of a code in milliseconds
  function automatic logic [11:0] tmeas_ms(input logic [1:0] code);
    case (code)
      2'h0: tmeas_ms = TMEAS0_MS;
      2'h1: tmeas_ms = TMEAS1_MS;
      2'h2: tmeas_ms = TMEAS2_MS;
      default: tmeas_ms = TMEAS3_MS;
    endcase
  endfunction

endpackage

/* verilog/hms_scheduler.sv */
// hms_scheduler: configuration registers and measurement scheduler of a
// solar harvester; registers reached over Avalon-MM with waitrequest.
// assumes one 50 MHz clock, asynchronous active-low reset, and analog
// front ends that act on the measurement and thermal strobes.
module hms_scheduler #(
  parameter int TICK_CYCLES = hms_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [5:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWriteData,
  input wire logic [3:0] avByteEnable,
  output logic [31:0] avReadData,
  output logic avWaitRequest,
  input wire logic [15:0] harvestPulseCount,
  input wire logic sleepFlag,
  input wire logic sourceMeasureInhibit,
  input wire logic thermalMonitorEnable,
  input wire logic thermalHot,
  input wire logic interruptAssert,
  input wire logic sourceDischargeOut,
  output logic interruptPinOut,
  output logic interruptPinOe,
  output logic [2:0] wakeThresholdCode,
  output logic [4:0] mpptFractionCode,
  output logic sourceMeasureActive,
  output logic sourceMeasureDone,
  output logic thermalCheckStrobe,
  output logic boostThermalHalt,
  output logic harvestEnable
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic tick;
  logic [11:0] settleMs;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [3:0] regIdx;
  logic wrTake;
  hms_pkg::hms_cfg_type cfg_r;
  hms_pkg::hms_cfg_type cfg_nxt;
  logic forceSrcWr;
  logic forceThmWr;
  hms_pkg::hms_state_type state_r;
  hms_pkg::hms_state_type state_nxt;
  logic porPending_r;
  logic porPending_nxt;
  logic srcPending_r;
  logic srcPending_nxt;
  logic [11:0] settleCnt_r;
  logic [11:0] settleCnt_nxt;
  logic [17:0] periodCnt_r;
  logic [17:0] periodCnt_nxt;
  logic [12:0] adaptCnt_r;
  logic [12:0] adaptCnt_nxt;
  logic storedValid_r;
  logic storedValid_nxt;
  logic [15:0] storedCount_r;
  logic [15:0] storedCount_nxt;
  logic thmStrobe_r;
  logic thmStrobe_nxt;
  logic halt_r;
  logic halt_nxt;
  logic done_r;
  logic done_nxt;
  logic [17:0] periodMs;
  logic [12:0] adaptWaitMs;
  logic periodOn;
  logic periodEnd;
  logic ratioOut;

  ////////////////////////////////////////////////////////////////////////
  // time base and settle length
  hms_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .resetn(resetn),
    .tick(tick)
  );

  hms_settle_calc u_settle (
    .tmeasCode(cfg_r.tmeasCode),
    .adaptiveSettleEn(cfg_r.adaptiveSettleEn),
    .harvestPulseCount(harvestPulseCount),
    .settleMs(settleMs)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then the answer; writes land on ack
  always_comb begin
    regIdx = avAddress[5:2];
    avWaitRequest = (avRead | avWrite) & ~ack_r;
    ack_nxt = (avRead | avWrite) & ~ack_r;
    wrTake = avWrite & ack_r & avByteEnable[0];
    rdata_nxt = rdata_r;
    if (avRead & ~ack_r) begin
      rdata_nxt = 32'h0; // unmapped reads return zero
      case (regIdx)
        hms_pkg::IDX_WAKE_PERIOD: begin
          rdata_nxt[hms_pkg::WK_PERIODIC_SRC] = cfg_r.periodicSourceMeasureEn;
          rdata_nxt[hms_pkg::WK_PERIODIC_THM] = cfg_r.periodicThermalEn;
          rdata_nxt[hms_pkg::WK_DISCH_SEL] = cfg_r.irqPinToDischargeSel;
          rdata_nxt[hms_pkg::WK_THR_LSB +: 3] = cfg_r.wakeThresholdCode;
        end
        hms_pkg::IDX_MPPT_FRAC: begin
          rdata_nxt[4:0] = cfg_r.mpptFraction;
        end
        hms_pkg::IDX_MEAS_CFG: begin
          // force bits are write-only and read back as zero
          rdata_nxt[hms_pkg::MC_TMEAS_LSB +: 2] = cfg_r.tmeasCode;
          rdata_nxt[hms_pkg::MC_ADAPT_SETTLE] = cfg_r.adaptiveSettleEn;
          rdata_nxt[hms_pkg::MC_ADAPT_PERIOD] = cfg_r.adaptivePeriodEn;
          rdata_nxt[hms_pkg::MC_TPER_LSB +: 2] = cfg_r.tperCode;
        end
        hms_pkg::IDX_SCHED_STATUS: begin
          rdata_nxt = {storedCount_r, 8'h00, halt_r, storedValid_r,
            srcPending_r, porPending_r, 1'b0, state_r};
        end
        default: begin
          rdata_nxt = 32'h0;
        end
      endcase
    end
  end

  // register the bus answer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avReadData = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // configuration registers and the self-clearing force strobes
  always_comb begin
    cfg_nxt = cfg_r;
    forceSrcWr = 1'b0;
    forceThmWr = 1'b0;
    if (wrTake) begin
      case (regIdx)
        hms_pkg::IDX_WAKE_PERIOD: begin
          cfg_nxt.periodicSourceMeasureEn =
            avWriteData[hms_pkg::WK_PERIODIC_SRC];
          cfg_nxt.periodicThermalEn = avWriteData[hms_pkg::WK_PERIODIC_THM];
          cfg_nxt.irqPinToDischargeSel = avWriteData[hms_pkg::WK_DISCH_SEL];
          cfg_nxt.wakeThresholdCode = avWriteData[hms_pkg::WK_THR_LSB +: 3];
        end
        hms_pkg::IDX_MPPT_FRAC: begin
          cfg_nxt.mpptFraction = avWriteData[4:0];
        end
        hms_pkg::IDX_MEAS_CFG: begin
          forceSrcWr = avWriteData[hms_pkg::MC_FORCE_SRC];
          forceThmWr = avWriteData[hms_pkg::MC_FORCE_THM];
          cfg_nxt.tmeasCode = avWriteData[hms_pkg::MC_TMEAS_LSB +: 2];
          cfg_nxt.adaptiveSettleEn = avWriteData[hms_pkg::MC_ADAPT_SETTLE];
          cfg_nxt.adaptivePeriodEn = avWriteData[hms_pkg::MC_ADAPT_PERIOD];
          cfg_nxt.tperCode = avWriteData[hms_pkg::MC_TPER_LSB +: 2];
        end
        default: begin
          cfg_nxt = cfg_r;
        end
      endcase
    end
  end

  // register the configuration
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= hms_pkg::CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scheduler: period, adaptive capture, settle and thermal checks
  always_comb begin
    periodMs = 18'(hms_pkg::tmeas_ms(cfg_r.tmeasCode))
      << (hms_pkg::PERIOD_SHIFT_BASE + 32'(cfg_r.tperCode));
    adaptWaitMs = {hms_pkg::tmeas_ms(cfg_r.tmeasCode), 1'b0};
    periodOn = (cfg_r.tperCode != hms_pkg::TPER_DISABLED);
    periodEnd = periodOn & tick & (periodCnt_r + 18'h1 >= periodMs);
    // new/stored below one half or above two
    ratioOut = ({harvestPulseCount, 1'b0} < {1'b0, storedCount_r}) |
      ({1'b0, harvestPulseCount} > {storedCount_r, 1'b0});
    state_nxt = state_r;
    porPending_nxt = porPending_r;
    srcPending_nxt = srcPending_r;
    settleCnt_nxt = settleCnt_r;
    periodCnt_nxt = periodCnt_r;
    adaptCnt_nxt = adaptCnt_r;
    storedValid_nxt = storedValid_r;
    storedCount_nxt = storedCount_r;
    thmStrobe_nxt = 1'b0;
    halt_nxt = halt_r;
    done_nxt = 1'b0;
    // period counter runs in ms ticks
    if (!periodOn) begin
      periodCnt_nxt = 18'h0;
    end else if (periodEnd) begin
      periodCnt_nxt = 18'h0;
    end else if (tick) begin
      periodCnt_nxt = periodCnt_r + 18'h1;
    end
    // an idle scheduler takes the pending request here
    if (srcPending_r & state_r == hms_pkg::ST_IDLE) begin
      srcPending_nxt = 1'b0;
    end
    // requests for a source measurement; a set beats the take above
    if (forceSrcWr & ~sourceMeasureInhibit) begin
      srcPending_nxt = 1'b1;
    end
    if (periodEnd & cfg_r.periodicSourceMeasureEn & ~sourceMeasureInhibit) begin
      srcPending_nxt = 1'b1;
    end
    if (porPending_r & state_r == hms_pkg::ST_IDLE) begin
      porPending_nxt = 1'b0;
      if (cfg_r.periodicSourceMeasureEn & ~sourceMeasureInhibit) begin
        srcPending_nxt = 1'b1;
      end
    end
    // adaptive period: capture after twice Tmeas, then watch the ratio
    if (cfg_r.adaptivePeriodEn & periodOn & state_r == hms_pkg::ST_IDLE &
        tick) begin
      if (!storedValid_r) begin
        if (adaptCnt_r + 13'h1 >= adaptWaitMs) begin
          storedValid_nxt = 1'b1;
          storedCount_nxt = harvestPulseCount;
        end else begin
          adaptCnt_nxt = adaptCnt_r + 13'h1;
        end
      end else if (ratioOut & ~sleepFlag & ~sourceMeasureInhibit) begin
        srcPending_nxt = 1'b1;
      end
    end
    // thermal checks on period end or on request, only when enabled
    if (thermalMonitorEnable & ((periodEnd & cfg_r.periodicThermalEn) |
        forceThmWr)) begin
      thmStrobe_nxt = 1'b1;
    end
    if (thmStrobe_r) begin
      halt_nxt = thermalHot;
    end
    if (!thermalMonitorEnable) begin
      halt_nxt = 1'b0;
    end
    // measurement sequence
    case (state_r)
      hms_pkg::ST_IDLE: begin
        if (srcPending_r) begin
          settleCnt_nxt = 12'h0;
          state_nxt = hms_pkg::ST_SETTLE;
        end
      end
      hms_pkg::ST_SETTLE: begin
        if (tick) begin
          if (settleCnt_r + 12'h1 >= settleMs) begin
            state_nxt = hms_pkg::ST_DONE;
          end else begin
            settleCnt_nxt = settleCnt_r + 12'h1;
          end
        end
      end
      hms_pkg::ST_DONE: begin
        done_nxt = 1'b1;
        periodCnt_nxt = 18'h0;
        adaptCnt_nxt = 13'h0;
        storedValid_nxt = 1'b0;
        state_nxt = hms_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = hms_pkg::ST_IDLE;
      end
    endcase
  end

  // register the scheduler state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= hms_pkg::ST_IDLE;
      porPending_r <= 1'b1;
      srcPending_r <= 1'b0;
      settleCnt_r <= 12'h0;
      periodCnt_r <= 18'h0;
      adaptCnt_r <= 13'h0;
      storedValid_r <= 1'b0;
      storedCount_r <= 16'h0;
      thmStrobe_r <= 1'b0;
      halt_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      porPending_r <= porPending_nxt;
      srcPending_r <= srcPending_nxt;
      settleCnt_r <= settleCnt_nxt;
      periodCnt_r <= periodCnt_nxt;
      adaptCnt_r <= adaptCnt_nxt;
      storedValid_r <= storedValid_nxt;
      storedCount_r <= storedCount_nxt;
      thmStrobe_r <= thmStrobe_nxt;
      halt_r <= halt_nxt;
      done_r <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    if (cfg_r.irqPinToDischargeSel) begin
      interruptPinOe = 1'b1;
      interruptPinOut = sourceDischargeOut;
    end else begin
      interruptPinOe = interruptAssert;
      interruptPinOut = 1'b0;
    end
  end

  assign wakeThresholdCode = cfg_r.wakeThresholdCode;
  assign mpptFractionCode = cfg_r.mpptFraction;
  assign sourceMeasureActive = (state_r == hms_pkg::ST_SETTLE);
  assign sourceMeasureDone = done_r;
  assign thermalCheckStrobe = thmStrobe_r;
  assign boostThermalHalt = halt_r;
  assign harvestEnable = ~sleepFlag;

endmodule

/* verilog/hms_settle_calc.sv */
// hms_settle_calc: settling time in milliseconds from the time code,
// optionally scaled by the present harvest pulse count.
// assumes the harvest count is a steady level from the counter block.
module hms_settle_calc (
  input wire logic [1:0] tmeasCode,
  input wire logic adaptiveSettleEn,
  input wire logic [15:0] harvestPulseCount,
  output logic [11:0] settleMs
);

  logic [11:0] baseMs;

  // strong harvest settles fast, weak harvest gets up to twice the base
  always_comb begin
    baseMs = hms_pkg::tmeas_ms(tmeasCode);
    if (!adaptiveSettleEn) begin
      settleMs = baseMs;
    end else if (harvestPulseCount >= hms_pkg::HARV_FAST) begin
      settleMs = baseMs >> 2;
    end else if (harvestPulseCount >= hms_pkg::HARV_MID) begin
      settleMs = baseMs >> 1;
    end else if (harvestPulseCount >= hms_pkg::HARV_SLOW) begin
      settleMs = baseMs;
    end else begin
      settleMs = baseMs << 1;
    end
  end

endmodule

/* verilog/hms_tick_div.sv */
// hms_tick_div: divides the system clock into a one-cycle tick enable.
// assumes clk is the only clock; tick is high one cycle in TICK_CYCLES.
module hms_tick_div #(
  parameter int TICK_CYCLES = hms_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;

  // count down to zero, then reload
  always_comb begin
    tick = (cnt_r == 32'h0);
    cnt_nxt = tick ? 32'(TICK_CYCLES - 1) : cnt_r - 32'h1;
  end

  // register the divider count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule
